/* design/spcd_pkg.sv */
// Purpose: constants and carriers for the byte-wide serial port
// Assumes: 8-bit registers behind a plain strobe port, one word per index
// Notes: flags register is read-only, data register is split rx/tx
package spcd_pkg;

	localparam int         ADDR_W      = 3;
	localparam logic [2:0] OFF_MAIN    = 3'h0;
	localparam logic [2:0] OFF_OPT     = 3'h1;
	localparam logic [2:0] OFF_BR      = 3'h2;
	localparam logic [2:0] OFF_FLAGS   = 3'h3;
	localparam logic [2:0] OFF_DATA    = 3'h4;

	// main_control_reg fields
	localparam int MC_RIE  = 7;
	localparam int MC_EN   = 6;
	localparam int MC_TIE  = 5;
	localparam int MC_MASTER_SELECT = 4;
	localparam int MC_CPOL = 3;
	localparam int MC_CPHA = 2;
	localparam int MC_SELECT_OUTPUT_ENABLE = 1;
	localparam int MC_LSBF = 0;

	// option_control_reg fields
	localparam int OC_FEN   = 4;
	localparam int OC_DRV   = 3;
	localparam int OC_HALT  = 1;
	localparam int OC_SWIRE = 0;

	// flag_reg fields
	localparam int FL_RXF = 7;
	localparam int FL_TXE = 5;
	localparam int FL_FLT = 4;

	// bit_rate_reg fields
	localparam int BR_PRE_LSB  = 4;
	localparam int BR_RATE_LSB = 0;
	localparam int SEL_W       = 3;

	localparam logic [7:0] OPT_MASK  = 8'h1B;
	localparam logic [7:0] BR_MASK   = 8'h77;
	localparam logic [7:0] FLAG_MASK = 8'hB0;

	localparam logic [7:0] MAIN_RST  = 8'h00;
	localparam logic [7:0] OPT_RST   = 8'h00;
	localparam logic [7:0] BR_RST    = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h20;

	// clock edges in one byte transfer
	localparam logic [4:0] XFER_EDGES = 5'h10;

	typedef struct packed {
		logic             wr;
		logic             rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0]       wdata;
	} spcd_req_s;

	typedef struct packed {
		logic serial_clk;
		logic master_out_pin;
		logic master_in_pin;
		logic slave_select_pin;
	} spcd_pin_in_s;

	typedef struct packed {
		logic serial_clk;
		logic serial_clk_oe;
		logic master_out_pin;
		logic master_out_pin_oe;
		logic master_in_pin;
		logic master_in_pin_oe;
		logic slave_select_pin;
		logic slave_select_pin_oe;
	} spcd_pins_s;

endpackage

/* design/spcd_sync.sv */
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module spcd_sync #(
	parameter int W = 4
) (
	input  logic         clk,
	input  logic         reset,
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} spcd_sync_s;

	spcd_sync_s st;
	spcd_sync_s n;

	always_comb begin
		n    = st;
		n.s1 = d;
		n.s2 = st.s1;
		n.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				n.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

	assign q = st.q;
endmodule // spcd_sync

/* design/spcd_baud.sv */
// Purpose: prescaler and rate divider for the master bit clock
// Assumes: run is held for the whole transfer
// Notes: tick marks each half bit, i.e. every serial clock edge
`timescale 1ns/1ps
module spcd_baud #(
	parameter int PRE_W  = 3,
	parameter int RATE_W = 3
) (
	input  logic              clk,
	input  logic              reset,
	input  logic              run,
	input  logic              hold,
	input  logic [PRE_W-1:0]  pre_sel,
	input  logic [RATE_W-1:0] rate_sel,
	output logic              tick
);
	localparam int CNT_W = (1 << RATE_W) - 1;

	typedef struct packed {
		logic [PRE_W-1:0] pcnt;
		logic [CNT_W-1:0] rcnt;
		logic             tick;
	} spcd_baud_s;

	spcd_baud_s       st;
	spcd_baud_s       n;
	logic [CNT_W-1:0] rlast;

	// half bit = (pre_sel+1) * 2**rate_sel, full bit = (pre_sel+1) * 2**(rate_sel+1)
	assign rlast = CNT_W'((1 << rate_sel) - 1);

	always_comb begin
		n      = st;
		n.tick = 1'b0;
		if (!run) begin
			n = '0;
		end else if (!hold) begin
			if (st.pcnt == pre_sel) begin
				n.pcnt = '0;
				if (st.rcnt == rlast) begin
					n.rcnt = '0;
					n.tick = 1'b1;
				end else begin
					n.rcnt = CNT_W'(st.rcnt + 1'b1);
				end
			end else begin
				n.pcnt = PRE_W'(st.pcnt + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

	assign tick = st.tick;
endmodule // spcd_baud

/* design/spcd_top.sv */
// Purpose: byte-wide serial port, master or slave, with register port
// Assumes: read data one cycle after read strobe; pins pass synchroniser
// Notes: master sampling needs at least 10 bus cycles per bit, for synchroniser lag
//
// Contract
// - option register reads zero in bits 7, 6, 5 and 2.
// - fault detect enable ignored as slave; as master selects select-pin role.
// - in single-wire mode drive enable turns the data driver on or off.
// - halt-in-wait set stops the port while the processor waits.
// - single-wire select uses one data pin: out pin as master, in pin as slave.
// - bit rate register may be read or written at any time.
// - prescaler divides bus clock by prescale field plus one.
// - rate divider divides prescaler output by two to field plus one.
// - flag register read-only, unused bits zero, writes change nothing.
// - receive full set at transfer end, cleared by flag read then data read.
// - transmit empty cleared by flag read then data write; else write ignored.
// - transmit empty set on move to shifter, within two cycles when idle.
// - queued byte moves into shifter when shifter finishes.
// - interrupt requested while transmit empty and transmit enable set.
// - fault set on select low only as master, detect on, select output off.
// - fault cleared by reading it set, then writing main control.
// - data read gives receive buffer, write loads transmit buffer, master starts.
// - unread receive buffer at transfer end keeps old byte, records overrun.
// - on fault clear master mode and switch off clock and data drivers.
// - receive enable gates requests from receive full and fault.
// - disabling halts transfer, flushes buffers, clears receive full, sets empty.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module spcd_top (
	input  logic                   clk,
	input  logic                   reset,
	input  spcd_pkg::spcd_req_s    bus,
	output logic [7:0]             rdata,
	input  logic                   wait_mode,
	input  spcd_pkg::spcd_pin_in_s pin_in,
	output spcd_pkg::spcd_pins_s   pin_out,
	output logic                   irq,
	output logic                   rx_overrun
);
	import spcd_pkg::*;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] opt;
		logic [7:0] br;
		logic       rx_full;
		logic       tx_empty;
		logic       fault;
		logic       rx_arm;
		logic       tx_arm;
		logic       f_arm;
		logic [7:0] txbuf;
		logic       tx_pend;
		logic [7:0] shreg;
		logic       cap;
		logic [4:0] edges;
		logic       busy;
		logic [7:0] rxbuf;
		logic       ovr;
		logic [7:0] rdata;
		logic       irq;
		spcd_pins_s pins;
		logic       sck_d;
	} spcd_state_s;

	localparam spcd_state_s ST_RST = '{
		ctl:      MAIN_RST,
		opt:      OPT_RST,
		br:       BR_RST,
		rx_full:  FLAGS_RST[FL_RXF],
		tx_empty: FLAGS_RST[FL_TXE],
		fault:    FLAGS_RST[FL_FLT],
		default:  '0
	};

	spcd_state_s  st;
	spcd_state_s  n;
	spcd_pin_in_s pin_q;
	logic         tick;
	logic         freeze;
	logic         ss_lo;
	logic         din;
	logic         step;
	logic         sample;
	logic         done;
	logic         fault_cond;
	logic         live;
	logic [4:0]   e_next;
	logic [7:0]   rd_val;
	logic [7:0]   rx_word;

	function automatic logic [7:0] bit_order(input logic [7:0] b, input logic lsb);
		logic [7:0] r;
		// stream result kept in a variable: strict tools refuse it as an operand
		r = {<<{b}};
		return lsb ? r : b;
	endfunction

	spcd_sync #(
		.W(4)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.d(pin_in),
		.q(pin_q)
	);

	spcd_baud #(
		.PRE_W(SEL_W),
		.RATE_W(SEL_W)
	) u_baud (
		.clk(clk),
		.reset(reset),
		.run(st.busy && st.ctl[MC_MASTER_SELECT] && st.ctl[MC_EN]),
		.hold(freeze),
		.pre_sel(st.br[BR_PRE_LSB +: SEL_W]),
		.rate_sel(st.br[BR_RATE_LSB +: SEL_W]),
		.tick(tick)
	);

	assign freeze = st.opt[OC_HALT] && wait_mode;
	assign ss_lo  = !pin_q.slave_select_pin;
	// master reads in pin unless single wire; slave the reverse
	assign din    = (st.ctl[MC_MASTER_SELECT] ^ st.opt[OC_SWIRE]) ?
		pin_q.master_in_pin : pin_q.master_out_pin;
	// select pin is a fault input only in this one setting
	assign fault_cond = st.ctl[MC_EN] && st.ctl[MC_MASTER_SELECT] && st.opt[OC_FEN]
		&& !st.ctl[MC_SELECT_OUTPUT_ENABLE] && ss_lo;
	assign step = !freeze && st.ctl[MC_EN] && !fault_cond && (st.ctl[MC_MASTER_SELECT] ?
		tick : (ss_lo && pin_q.serial_clk != st.sck_d));
	assign e_next  = 5'(st.edges + 5'd1);
	// odd edges lead; phase picks leading or trailing for sampling
	assign sample  = e_next[0] ^ st.ctl[MC_CPHA];
	assign done    = step && e_next == XFER_EDGES;
	assign rx_word = bit_order({st.shreg[6:0], st.ctl[MC_CPHA] ? din : st.cap},
		st.ctl[MC_LSBF]);

	always_comb begin
		n       = st;
		rd_val  = 8'h00;
		live    = 1'b0;
		n.sck_d = pin_q.serial_clk;

		if (bus.wr) begin
			case (bus.addr)
				OFF_MAIN: begin
					n.ctl = bus.wdata;
					if (st.f_arm) begin
						n.fault = 1'b0;
						n.f_arm = 1'b0;
					end
				end
				OFF_OPT: n.opt = bus.wdata & OPT_MASK;
				OFF_BR: n.br = bus.wdata & BR_MASK;
				OFF_DATA: begin
					// unarmed writes are dropped, protecting a queued byte
					if (st.tx_arm) begin
						n.txbuf    = bus.wdata;
						n.tx_pend  = 1'b1;
						n.tx_empty = 1'b0;
						n.tx_arm   = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		if (bus.rd) begin
			case (bus.addr)
				OFF_MAIN: rd_val = st.ctl;
				OFF_OPT: rd_val = st.opt;
				OFF_BR: rd_val = st.br;
				OFF_FLAGS: begin
					rd_val[FL_RXF] = st.rx_full;
					rd_val[FL_TXE] = st.tx_empty;
					rd_val[FL_FLT] = st.fault;
					n.rx_arm       = st.rx_full;
					n.tx_arm       = st.tx_empty;
					n.f_arm        = st.fault;
				end
				OFF_DATA: begin
					rd_val = st.rxbuf;
					if (st.rx_arm) begin
						n.rx_full = 1'b0;
						n.rx_arm  = 1'b0;
						n.ovr     = 1'b0;
					end
				end
				default: rd_val = 8'h00;
			endcase
		end
		n.rdata = rd_val;

		if (step) begin
			n.edges = done ? 5'd0 : e_next;
			n.busy  = !done;
			if (sample) begin
				n.cap = din;
			end else if (!(st.ctl[MC_CPHA] && st.edges == 5'd0)) begin
				n.shreg = {st.shreg[6:0], st.cap};
			end
		end

		// slave frame dropped when select rises early
		if (!st.ctl[MC_MASTER_SELECT] && !ss_lo) begin
			n.edges = 5'd0;
			n.busy  = 1'b0;
		end

		if (done) begin
			// a clearing read in this very cycle frees the buffer first
			if (n.rx_full) begin
				n.ovr = 1'b1;
			end else begin
				n.rxbuf   = rx_word;
				n.rx_full = 1'b1;
			end
		end

		if (!freeze && st.ctl[MC_EN] && st.tx_pend && !st.busy && !done) begin
			n.shreg    = bit_order(st.txbuf, st.ctl[MC_LSBF]);
			n.tx_pend  = 1'b0;
			n.tx_empty = 1'b1;
			n.busy     = st.ctl[MC_MASTER_SELECT];
			n.edges    = 5'd0;
		end

		if (fault_cond) begin
			n.fault        = 1'b1;
			n.ctl[MC_MASTER_SELECT] = 1'b0;
			n.busy         = 1'b0;
			n.edges        = 5'd0;
		end

		if (!st.ctl[MC_EN]) begin
			n.busy     = 1'b0;
			n.edges    = 5'd0;
			n.tx_pend  = 1'b0;
			n.rx_full  = 1'b0;
			n.tx_empty = 1'b1;
			n.ovr      = 1'b0;
		end

		// drivers follow next state so they change with the flags
		live   = n.ctl[MC_EN] && !n.fault;
		n.pins = '0;
		n.pins.serial_clk     = n.ctl[MC_CPOL] ^ n.edges[0];
		n.pins.serial_clk_oe  = live && n.ctl[MC_MASTER_SELECT];
		n.pins.master_out_pin = n.shreg[7];
		n.pins.master_in_pin  = n.shreg[7];
		n.pins.master_out_pin_oe = live && n.ctl[MC_MASTER_SELECT]
			&& (!n.opt[OC_SWIRE] || n.opt[OC_DRV]);
		n.pins.master_in_pin_oe  = live && !n.ctl[MC_MASTER_SELECT] && ss_lo
			&& (!n.opt[OC_SWIRE] || n.opt[OC_DRV]);
		n.pins.slave_select_pin    = !n.busy;
		n.pins.slave_select_pin_oe = live && n.ctl[MC_MASTER_SELECT] && n.opt[OC_FEN]
			&& n.ctl[MC_SELECT_OUTPUT_ENABLE];
		n.irq = ((n.rx_full || n.fault) && n.ctl[MC_RIE])
			|| (n.tx_empty && n.ctl[MC_TIE]);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= ST_RST;
		end else begin
			st <= n;
		end
	end

	assign rdata      = st.rdata;
	assign pin_out    = st.pins;
	assign irq        = st.irq;
	assign rx_overrun = st.ovr;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_opt_zero;
		bus.rd && bus.addr == OFF_OPT |=> (rdata & ~OPT_MASK) == 8'h00;
	endproperty
	a_opt_zero: assert property (p_opt_zero) else $error("option reserved bits set");

	property p_flag_zero;
		bus.rd && bus.addr == OFF_FLAGS |=> (rdata & ~FLAG_MASK) == 8'h00;
	endproperty
	a_flag_zero: assert property (p_flag_zero) else $error("flag reserved bits set");

	property p_wr_ignored;
		bus.wr && bus.addr == OFF_DATA && !st.tx_arm |=> $stable(st.txbuf);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) else $error("unarmed data write taken");

	property p_idle_refill;
		bus.wr && bus.addr == OFF_DATA && st.tx_arm && st.ctl[MC_EN] && st.ctl[MC_MASTER_SELECT]
			&& !st.busy && !st.tx_pend && !st.opt[OC_HALT] |-> ##[1:2] st.tx_empty;
	endproperty
	a_idle_refill: assert property (p_idle_refill) else $error("empty flag late");

	property p_rx_hold;
		st.rx_full && st.ctl[MC_EN] && !(bus.rd && bus.addr == OFF_DATA && st.rx_arm)
			|=> st.rx_full;
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("receive full lost");

	property p_fault_cause;
		$rose(st.fault) |-> $past(fault_cond);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");

	property p_fault_quiet;
		$rose(st.fault) |-> !st.ctl[MC_MASTER_SELECT] && !pin_out.serial_clk_oe
			&& !pin_out.master_out_pin_oe;
	endproperty
	a_fault_quiet: assert property (p_fault_quiet) else $error("drivers on after fault");

	property p_tx_irq;
		st.tx_empty && st.ctl[MC_TIE] |-> irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit request missing");

	property p_disable;
		!st.ctl[MC_EN] |=> st.tx_empty && !st.rx_full && !st.busy;
	endproperty
	a_disable: assert property (p_disable) else $error("disable did not flush");

	property p_queue_move;
		st.tx_pend && !st.busy && st.ctl[MC_EN] && !freeze && !done
			|=> st.tx_empty && !st.tx_pend;
	endproperty
	a_queue_move: assert property (p_queue_move) else $error("queued byte not moved");

	property p_overrun_keep;
		done && st.rx_full && !(bus.rd && bus.addr == OFF_DATA && st.rx_arm)
			|=> st.ovr && $stable(st.rxbuf);
	endproperty
	a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost old byte");

	property p_swire_quiet;
		st.opt[OC_SWIRE] && !st.opt[OC_DRV]
			|-> !pin_out.master_out_pin_oe && !pin_out.master_in_pin_oe;
	endproperty
	a_swire_quiet: assert property (p_swire_quiet) else $error("single wire driver on");

	c_master_done: cover property (done && st.ctl[MC_MASTER_SELECT]);
	c_slave_done: cover property (done && !st.ctl[MC_MASTER_SELECT]);
	c_fault: cover property ($rose(st.fault));
	c_overrun: cover property ($rose(st.ovr));
endmodule // spcd_top

/* verif/spcd_slave_model.sv */
// Purpose: behavioural far-side slave for the serial port bench
// Assumes: clock idles low, data taken on rising edge, msb first
// Notes: deselected data line shows inverse of last bit, never a held value
`timescale 1ns/1ps
module spcd_slave_model (
	input  wire logic       sck,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	input  wire logic [7:0] load,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh   = 8'h00;
	logic       last = 1'b0;

	initial got = 8'h00;
	always @(negedge sel_n) sh = load;
	always @(posedge sck) if (!sel_n) got = {got[6:0], mosi};
	always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
	always @* begin
		if (!sel_n) begin
			miso = sh[7];
			last = sh[7];
		end else begin
			miso = ~last;
		end
	end
endmodule // spcd_slave_model

/* verif/tb_spcd_top.sv */
// Purpose: self-checking bench for the serial port register block
// Assumes: partner is a mode-0 slave; random seed fixed at 49
// Notes: rates kept at 16+ cycles per bit for synchroniser sampling
`timescale 1ns/1ps
module tb_spcd_top;
	import spcd_pkg::*;
	logic         clk, reset, wait_mode, ss_tb, irq, rx_overrun, miso_m, sck_q;
	spcd_req_s    bus;
	logic [7:0]   rdata, sl_load, sl_got;
	spcd_pin_in_s pin_in;
	spcd_pins_s   pin_out;
	logic [31:0]  seed = 32'h0000_0031;
	int           miscompares = 0, n_tests = 0, cyc = 0, cnt = 0, half = 0, ntog = 0;

	spcd_top u_spcd_top (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
		.wait_mode(wait_mode), .pin_in(pin_in), .pin_out(pin_out), .irq(irq),
		.rx_overrun(rx_overrun));
	spcd_slave_model u_spcd_slave_model (.sck(pin_in.serial_clk),
		.sel_n(pin_in.slave_select_pin), .mosi(pin_in.master_out_pin),
		.load(sl_load), .miso(miso_m), .got(sl_got));
	// released lines: clock pulled low, out pin pulled high, in pin from the slave model, select from ss_tb
	assign pin_in.serial_clk = pin_out.serial_clk_oe ? pin_out.serial_clk : 1'b0;
	assign pin_in.master_out_pin = pin_out.master_out_pin_oe ? pin_out.master_out_pin : 1'b1;
	assign pin_in.master_in_pin = pin_out.master_in_pin_oe ? pin_out.master_in_pin : miso_m;
	assign pin_in.slave_select_pin = pin_out.slave_select_pin_oe ? pin_out.slave_select_pin : ss_tb;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// half measures the gap between serial clock edges
	always @(negedge clk) begin
		cyc <= cyc + 1;
		sck_q <= pin_out.serial_clk;
		if (pin_out.serial_clk !== sck_q) begin
			half <= cnt;
			cnt <= 1;
			ntog <= ntog + 1;
		end else begin
			cnt <= cnt + 1;
		end
		if (cyc == 60000) begin
			miscompares++;
			close_out();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// wire order of a byte when lsb first is chosen
	function automatic logic [7:0] rev(input logic [7:0] b, input logic on);
		logic [7:0] r;
		for (int k = 0; k < 8; k++) r[k] = b[7 - k];
		return on ? r : b;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		logic [7:0] d, b1, b2;
		logic [2:0] pre, rate;
		logic       lsb;
		int         t;
		reset = 1'b1;
		wait_mode = 1'b0;
		ss_tb = 1'b1;
		sl_load = 8'h00;
		bus = '0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) rchk(3'(i), i == 3 ? 8'h20 : 8'h00);
		wr(OFF_MAIN, 8'h20);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({7'h0, irq}, 8'h01);
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			d = 8'(rnd());
			wr(OFF_OPT, d);
			rchk(OFF_OPT, d & 8'h1B);
			wr(OFF_BR, ~d);
			rchk(OFF_BR, ~d & 8'h77);
			wr(OFF_FLAGS, d);
			rchk(OFF_FLAGS, 8'h20);
		end
		// slave, master without detect, master driving select, master detecting
		for (int i = 0; i < 4; i++) begin
			wr(OFF_OPT, i == 1 ? 8'h00 : 8'h10);
			wr(OFF_MAIN, i == 0 ? 8'h40 : (i == 2 ? 8'h52 : 8'h50));
			ss_tb <= 1'b0;
			repeat (8) @(posedge clk);
			rchk(OFF_FLAGS, i == 3 ? 8'h30 : 8'h20);
			if (i == 3) begin
				rchk(OFF_MAIN, 8'h40);
				chk({6'h0, pin_out.serial_clk_oe, pin_out.master_out_pin_oe}, 8'h00);
			end
			ss_tb <= 1'b1;
			wr(OFF_MAIN, 8'h00);
		end
		rchk(OFF_FLAGS, 8'h20);
		wr(OFF_OPT, 8'h10);
		for (int i = 0; i < 3; i++) begin
			pre = 3'(rnd());
			rate = 3'(2 + rnd() % 2);
			// half bit of 4 cycles is shorter than the pin synchroniser lag
			if (rate == 3'h2 && pre == 3'h0) pre = 3'h1;
			lsb = (i == 1);
			b1 = 8'(rnd());
			b2 = 8'(rnd());
			sl_load <= 8'(rnd());
			wr(OFF_BR, {1'b0, pre, 1'b0, rate});
			wr(OFF_MAIN, {7'h29, lsb});
			rchk(OFF_FLAGS, 8'h20);
			wr(OFF_DATA, b1);
			@(posedge clk);
			rchk(OFF_FLAGS, 8'h20);
			wr(OFF_DATA, b2);
			rchk(OFF_FLAGS, 8'h00);
			wr(OFF_DATA, ~b2);
			rchk(OFF_BR, {1'b0, pre, 1'b0, rate});
			d = 8'h00;
			for (int k = 0; k < 3000 && d[7] !== 1'b1; k++) rd(OFF_FLAGS, d);
			rchk(OFF_FLAGS, 8'hA0);
			chk(sl_got, rev(b1, lsb));
			chk({7'h0, irq}, 8'h00);
			wr(OFF_MAIN, {7'h69, lsb});
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk({7'h0, irq}, 8'h01);
			for (int k = 0; k < 3000 && rx_overrun !== 1'b1; k++) @(posedge clk);
			chk({7'h0, rx_overrun}, 8'h01);
			chk(8'(half), ({5'h00, pre} + 8'h01) << rate);
			chk(sl_got, rev(b2, lsb));
			rchk(OFF_FLAGS, 8'hA0);
			rchk(OFF_DATA, rev(sl_load, lsb));
			rchk(OFF_FLAGS, 8'h20);
			wr(OFF_MAIN, 8'h00);
		end
		// single wire, drive on, halt in wait; then disable with the byte still queued
		wr(OFF_OPT, 8'h1B);
		wr(OFF_MAIN, 8'h52);
		wait_mode <= 1'b1;
		rd(OFF_FLAGS, d);
		wr(OFF_DATA, 8'h5A);
		repeat (3) @(posedge clk);
		t = ntog;
		repeat (100) @(posedge clk);
		chk(8'(ntog - t), 8'h00);
		chk({6'h0, pin_out.master_out_pin_oe, pin_out.master_in_pin_oe}, 8'h02);
		wr(OFF_MAIN, 8'h00);
		wait_mode <= 1'b0;
		rchk(OFF_FLAGS, 8'h20);
		repeat (100) @(posedge clk);
		chk(8'(ntog - t), 8'h00);
		close_out();
	end
endmodule // tb_spcd_top
